/* amp_ctrl_pkg.sv */
// Functional notes
// - Writing 1 to reset-control bit 4 resets registers and pulses the DSP clear.
// - Writing 1 to reset-control bit 0 resets only the control registers.
// - Reset-control bits 7-5 are reserved, reset to 000; bits 3-1 read zero.
// - Reset-control register reads 0x00 after device reset.
// - Device-control-one holds frequency, bridge and modulation fields, resets to 0x00.
// - Bits 6-4 pick switching rate: 384K, 480K, 576K or 768K; others reserved.
// - Bit 2 selects bridge-tied output at 0 and parallel-bridge output at 1.
// - Bits 1-0 select dual-phase, single-sided or hybrid modulation.
package amp_ctrl_pkg;

  localparam int NUM_RW = 37;
  localparam int NUM_RO = 9;
  localparam int ADDR_W = 7;

  localparam logic [7:0] OFS_RESET_CONTROL = 8'h01;
  localparam logic [7:0] OFS_DEVICE_CONTROL_ONE = 8'h02;

  localparam logic [7:0] RW_OFFSET [NUM_RW] = '{
    8'h03, 8'h0F, 8'h28, 8'h29, 8'h30, 8'h31, 8'h33, 8'h34,
    8'h40, 8'h46, 8'h4C, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h53,
    8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5C,
    8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h6A,
    8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F
  };

  localparam logic [7:0] RO_OFFSET [NUM_RO] = '{
    8'h37, 8'h38, 8'h39, 8'h5B, 8'h5E, 8'h67, 8'h68, 8'h69, 8'h70
  };

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] RSV_HI_RESET = 3'h0;

  localparam int FULL_RESET_BIT = 4;
  localparam int REG_RESET_BIT = 0;
  localparam int RSV_HI_MSB = 7;
  localparam int RSV_HI_LSB = 5;
  localparam int FREQ_MSB = 6;
  localparam int FREQ_LSB = 4;
  localparam int BRIDGE_BIT = 2;
  localparam int MOD_MSB = 1;
  localparam int MOD_LSB = 0;

  localparam logic [2:0] FSW_384K = 3'h0;
  localparam logic [2:0] FSW_480K = 3'h2;
  localparam logic [2:0] FSW_576K = 3'h3;
  localparam logic [2:0] FSW_768K = 3'h4;
  localparam logic [9:0] RATE_384K = 10'h180;
  localparam logic [9:0] RATE_480K = 10'h1E0;
  localparam logic [9:0] RATE_576K = 10'h240;
  localparam logic [9:0] RATE_768K = 10'h300;

  localparam logic [1:0] MOD_DUAL_PHASE = 2'h0;
  localparam logic [1:0] MOD_SINGLE_SIDED = 2'h1;
  localparam logic [1:0] MOD_HYBRID = 2'h2;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_SUB = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK = 7'h10,
    ST_RDATA = 7'h20,
    ST_MACK = 7'h40
  } port_state_t;

  typedef struct packed {
    logic [2:0] switch_freq_select;
    logic bridge_parallel_select;
    logic [1:0] modulation_scheme;
  } amp_mode_t;

  typedef struct packed {
    logic bridge_tied_output;
    logic parallel_bridge_output;
    logic dual_phase_modulation;
    logic single_sided_modulation;
    logic hybrid_modulation;
  } amp_stage_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : amp_ctrl_pkg

/* pin_filter.sv */
`timescale 1ns/1ns
module pin_filter
  import amp_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic raw,
  output logic level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // The bus idles high, so the filter starts high to avoid a false start.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_reg <= 1'h1;
      s2_reg <= 1'h1;
      s3_reg <= 1'h1;
      level <= 1'h1;
    end
    else
    begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        level <= s3_reg;
      end
    end
  end

endmodule : pin_filter

/* amp_control_port_regs.sv */
`timescale 1ns/1ns
module amp_control_port_regs
  import amp_ctrl_pkg::*;
#(
  // Arbitrary value; the real target address is chosen by the integrator.
  parameter logic [ADDR_W-1:0] DEVICE_ADDR = 7'h2A
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [NUM_RO*8-1:0] ro_image,
  output logic [NUM_RW*8-1:0] rw_image,
  output amp_mode_t mode,
  output amp_stage_t stage,
  output logic [9:0] switch_rate_khz,
  output logic full_core_reset,
  output logic busy
);

  logic scl_lvl;
  logic sda_lvl;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  port_state_t state_reg;
  port_state_t state_next;
  port_state_t after_ack_reg;
  port_state_t after_ack_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic oe_reg;
  logic oe_next;
  logic nack_reg;
  logic nack_next;
  reg_write_t wr_reg;
  reg_write_t wr_next;

  logic [7:0] rd_data;
  logic [7:0] rd_fixed;
  logic [2:0] rsv_hi_reg;
  logic full_reset_reg;
  logic reg_reset_reg;
  logic regs_clear;
  logic wr_reset_ctrl;
  logic wr_dc1;
  logic [7:0] dc1_reg;
  logic [7:0] reset_ctrl_view;
  logic [7:0] rw_reg [NUM_RW];
  logic [7:0] rd_rw [NUM_RW];
  logic [7:0] rd_ro [NUM_RO];

  pin_filter u_scl_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(scl_in),
    .level(scl_lvl)
  );

  pin_filter u_sda_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(sda_in),
    .level(sda_lvl)
  );

  assign scl_rise = scl_lvl & ~scl_prev_reg;
  assign scl_fall = ~scl_lvl & scl_prev_reg;
  assign start_seen = scl_lvl & scl_prev_reg & sda_prev_reg & ~sda_lvl;
  assign stop_seen = scl_lvl & scl_prev_reg & ~sda_prev_reg & sda_lvl;

  // Open-drain data line: only ever pulled low.
  assign sda_out = 1'h0;
  assign sda_oe = oe_reg;
  assign busy = (state_reg != ST_IDLE);

  always_comb
  begin
    state_next = state_reg;
    after_ack_next = after_ack_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    nack_next = nack_reg;
    wr_next = '0;
    if (start_seen)
    begin
      state_next = ST_ADDR;
      bit_cnt_next = '0;
      oe_next = 1'h0;
    end
    else if (stop_seen)
    begin
      state_next = ST_IDLE;
      oe_next = 1'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
        end
        ST_ADDR, ST_SUB, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_lvl};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == BYTE_BITS)
          begin
            bit_cnt_next = '0;
            state_next = ST_ACK;
            oe_next = 1'h1;
            if (state_reg == ST_ADDR)
            begin
              after_ack_next = shift_reg[0] ? ST_RDATA : ST_SUB;
              if (shift_reg[7:1] != DEVICE_ADDR)
              begin
                state_next = ST_IDLE;
                oe_next = 1'h0;
              end
            end
            else if (state_reg == ST_SUB)
            begin
              ptr_next = shift_reg;
              after_ack_next = ST_WDATA;
            end
            else
            begin
              // Every byte is acknowledged; the pointer steps on after each one.
              wr_next = '{en: 1'h1, addr: ptr_reg, data: shift_reg};
              ptr_next = ptr_reg + 8'h01;
              after_ack_next = ST_WDATA;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            state_next = after_ack_reg;
            bit_cnt_next = '0;
            oe_next = 1'h0;
            if (after_ack_reg == ST_RDATA)
            begin
              tx_next = rd_data;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_data[7];
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == LAST_BIT)
            begin
              state_next = ST_MACK;
              oe_next = 1'h0;
            end
            else
            begin
              tx_next = {tx_reg[6:0], 1'h0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
              oe_next = ~tx_reg[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            nack_next = sda_lvl;
          end
          else if (scl_fall)
          begin
            if (nack_reg)
            begin
              state_next = ST_IDLE;
            end
            else
            begin
              state_next = ST_RDATA;
              bit_cnt_next = '0;
              tx_next = rd_data;
              ptr_next = ptr_reg + 8'h01;
              oe_next = ~rd_data[7];
            end
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          oe_next = 1'h0;
        end
      endcase
    end
  end

  // The serial engine is left out of the soft resets so a reset write
  // still completes its acknowledge cleanly.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      after_ack_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= '0;
      oe_reg <= 1'h0;
      nack_reg <= 1'h0;
      wr_reg <= '0;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end
    else
    begin
      state_reg <= state_next;
      after_ack_reg <= after_ack_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      nack_reg <= nack_next;
      wr_reg <= wr_next;
      scl_prev_reg <= scl_lvl;
      sda_prev_reg <= sda_lvl;
    end
  end

  assign wr_reset_ctrl = wr_reg.en && (wr_reg.addr == OFS_RESET_CONTROL);
  assign wr_dc1 = wr_reg.en && (wr_reg.addr == OFS_DEVICE_CONTROL_ONE);
  assign regs_clear = rst | full_reset_reg | reg_reset_reg;
  assign full_core_reset = full_reset_reg;

  // Both reset bits are one-cycle pulses, so they read back as zero once
  // the clear has landed.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      full_reset_reg <= 1'h0;
      reg_reset_reg <= 1'h0;
    end
    else
    begin
      full_reset_reg <= wr_reset_ctrl & wr_reg.data[FULL_RESET_BIT];
      reg_reset_reg <= wr_reset_ctrl & wr_reg.data[REG_RESET_BIT];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (regs_clear)
    begin
      rsv_hi_reg <= RSV_HI_RESET;
      dc1_reg <= REG_RESET;
    end
    else
    begin
      if (wr_reset_ctrl)
      begin
        rsv_hi_reg <= wr_reg.data[RSV_HI_MSB:RSV_HI_LSB];
      end
      if (wr_dc1)
      begin
        dc1_reg <= wr_reg.data;
      end
    end
  end

  // Bits 3-1 and the write-only bit 0 always read as zero.
  assign reset_ctrl_view = {rsv_hi_reg, full_reset_reg, 4'h0};

  assign mode.switch_freq_select = dc1_reg[FREQ_MSB:FREQ_LSB];
  assign mode.bridge_parallel_select = dc1_reg[BRIDGE_BIT];
  assign mode.modulation_scheme = dc1_reg[MOD_MSB:MOD_LSB];

  // A reserved frequency code keeps the last valid rate rather than
  // letting the output stage run at an undefined rate.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      switch_rate_khz <= RATE_384K;
      stage <= '0;
    end
    else
    begin
      case (mode.switch_freq_select)
        FSW_384K: switch_rate_khz <= RATE_384K;
        FSW_480K: switch_rate_khz <= RATE_480K;
        FSW_576K: switch_rate_khz <= RATE_576K;
        FSW_768K: switch_rate_khz <= RATE_768K;
        default: switch_rate_khz <= switch_rate_khz;
      endcase
      stage.bridge_tied_output <= ~mode.bridge_parallel_select;
      stage.parallel_bridge_output <= mode.bridge_parallel_select;
      stage.dual_phase_modulation <= (mode.modulation_scheme == MOD_DUAL_PHASE);
      stage.single_sided_modulation <= (mode.modulation_scheme == MOD_SINGLE_SIDED);
      stage.hybrid_modulation <= (mode.modulation_scheme == MOD_HYBRID);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_RW; g++)
    begin : g_rw
      always_ff @(posedge core_clk)
      begin
        if (regs_clear)
        begin
          rw_reg[g] <= REG_RESET;
        end
        else if (wr_reg.en && wr_reg.addr == RW_OFFSET[g])
        begin
          rw_reg[g] <= wr_reg.data;
        end
      end
      assign rw_image[g*8 +: 8] = rw_reg[g];
      assign rd_rw[g] = (ptr_reg == RW_OFFSET[g]) ? rw_reg[g] : 8'h00;
    end
    for (g = 0; g < NUM_RO; g++)
    begin : g_ro
      assign rd_ro[g] = (ptr_reg == RO_OFFSET[g]) ? ro_image[g*8 +: 8] : 8'h00;
    end
  endgenerate

  // Offsets outside the map match nothing: writes are dropped, reads give zero.
  assign rd_fixed = (ptr_reg == OFS_RESET_CONTROL) ? reset_ctrl_view
    : ((ptr_reg == OFS_DEVICE_CONTROL_ONE) ? dc1_reg : 8'h00);
  always_comb
  begin
    rd_data = rd_fixed;
    for (int i = 0; i < NUM_RW; i++)
    begin
      rd_data = rd_data | rd_rw[i];
    end
    for (int j = 0; j < NUM_RO; j++)
    begin
      rd_data = rd_data | rd_ro[j];
    end
  end

endmodule : amp_control_port_regs

/* amp_ctrl_props.sv */
`timescale 1ns/1ns
module amp_ctrl_props
  import amp_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sda_oe,
  input wire logic [NUM_RW*8-1:0] rw_image,
  input wire amp_mode_t mode,
  input wire amp_stage_t stage,
  input wire logic [9:0] switch_rate_khz,
  input wire logic full_core_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_core_pulse_short: assert property (full_core_reset |=> !full_core_reset)
    else $error("Core reset pulse lasted more than one cycle.");
  a_core_clears_regs: assert property (full_core_reset |-> ##[1:2] (rw_image == '0 && mode == '0))
    else $error("Core reset left registers set.");
  a_reset_values_zero: assert property ($past(rst) |-> (mode == '0 && rw_image == '0 && !sda_oe))
    else $error("Registers not zero after reset.");
  a_rate_slowest: assert property ((mode.switch_freq_select == FSW_384K) |=>
    (switch_rate_khz == RATE_384K))
    else $error("Lowest rate code decoded wrongly.");
  a_rate_fastest: assert property ((mode.switch_freq_select == FSW_768K) |=>
    (switch_rate_khz == RATE_768K))
    else $error("Highest rate code decoded wrongly.");
  // Reserved codes must not move the rate, so a stray write cannot retune the output stage.
  a_rate_reserved_hold: assert property ((mode.switch_freq_select inside {3'h1, 3'h5, 3'h6, 3'h7}) |=>
    $stable(switch_rate_khz))
    else $error("Reserved rate code changed the rate.");
  a_bridge_decode: assert property (!$past(rst) |->
    (stage.parallel_bridge_output == $past(mode.bridge_parallel_select)
    && stage.bridge_tied_output == !$past(mode.bridge_parallel_select)))
    else $error("Bridge select decoded wrongly.");
  a_mod_decode: assert property (!$past(rst) |->
    (stage.dual_phase_modulation == ($past(mode.modulation_scheme) == MOD_DUAL_PHASE)
    && stage.single_sided_modulation == ($past(mode.modulation_scheme) == MOD_SINGLE_SIDED)
    && stage.hybrid_modulation == ($past(mode.modulation_scheme) == MOD_HYBRID)))
    else $error("Modulation select decoded wrongly.");
endmodule : amp_ctrl_props

bind amp_control_port_regs amp_ctrl_props props_i (.core_clk(core_clk), .rst(rst),
  .sda_oe(sda_oe), .rw_image(rw_image), .mode(mode), .stage(stage),
  .switch_rate_khz(switch_rate_khz), .full_core_reset(full_core_reset));

/* ctrl_host.sv */
`timescale 1ns/1ns
module ctrl_host
(
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic pull_low;
  // The data line has a pull-up, so a released line reads high, never a stale value.
  assign sda = !(pull_low || sda_oe);
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hold
  task automatic start_cond();
    pull_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    pull_low = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : start_cond
  task automatic stop_cond();
    pull_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    pull_low = 1'b0;
    hold(8);
  endtask : stop_cond
  // Eight data bits and the acknowledge slot; data moves only while the clock is low.
  task automatic xfer9(input logic [8:0] din, output logic [8:0] dout);
    for (int i = 8; i >= 0; i--)
    begin
      pull_low = !din[i];
      hold(4);
      scl = 1'b1;
      hold(4);
      dout[i] = sda;
      hold(4);
      scl = 1'b0;
      hold(4);
    end
  endtask : xfer9
endmodule : ctrl_host

/* tb.sv */
`timescale 1ns/1ns
module tb
  import amp_ctrl_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A;
  logic core_clk, rst, scl, sda, sda_oe, sda_out, full_core_reset, busy;
  logic [NUM_RO*8-1:0] ro_image;
  logic [NUM_RW*8-1:0] rw_image, exp_rw;
  amp_mode_t mode;
  amp_stage_t stage;
  logic [9:0] switch_rate_khz, exp_rate;
  logic [7:0] d;
  int failures, cmp_count, pulses;
  int unsigned seed;

  ctrl_host host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  amp_control_port_regs #(.DEVICE_ADDR(DEV)) uut (.core_clk(core_clk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .ro_image(ro_image),
    .rw_image(rw_image), .mode(mode), .stage(stage), .switch_rate_khz(switch_rate_khz),
    .full_core_reset(full_core_reset), .busy(busy));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (full_core_reset === 1'b1)
      pulses <= pulses + 1;

  function automatic logic [9:0] rate_of(input logic [2:0] c, input logic [9:0] prev);
    case (c)
      FSW_384K: return RATE_384K;
      FSW_480K: return RATE_480K;
      FSW_576K: return RATE_576K;
      FSW_768K: return RATE_768K;
      default: return prev;
    endcase
  endfunction : rate_of
  function automatic amp_stage_t stage_of(input logic b, input logic [1:0] m);
    return {!b, b, m == MOD_DUAL_PHASE, m == MOD_SINGLE_SIDED, m == MOD_HYBRID};
  endfunction : stage_of

  task automatic chk(input string nm, input logic [295:0] seen, input logic [295:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    logic [8:0] ack;
    host.start_cond();
    host.xfer9({DEV, 1'b0, 1'b1}, ack);
    host.xfer9({ofs, 1'b1}, ack);
    host.xfer9({dat, 1'b1}, ack);
    host.stop_cond();
    chk("ack", ack[0], 1'b0);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] ofs, input logic [7:0] exp);
    logic [8:0] got;
    host.start_cond();
    chk("busy", busy, 1'b1);
    host.xfer9({DEV, 1'b0, 1'b1}, got);
    host.xfer9({ofs, 1'b1}, got);
    host.start_cond();
    host.xfer9({DEV, 1'b1, 1'b1}, got);
    host.xfer9(9'h1FF, got);
    host.stop_cond();
    chk(nm, got[8:1], exp);
  endtask : rd_chk
  task automatic soft_clear(input logic [7:0] val);
    wr(OFS_RESET_CONTROL, val);
    exp_rw = '0;
    exp_rate = RATE_384K;
    chk("rw_image", rw_image, exp_rw);
    chk("mode", mode, 6'h00);
    chk("rate", switch_rate_khz, exp_rate);
    chk("stage", stage, stage_of(1'b0, MOD_DUAL_PHASE));
    rd_chk("reset_control", OFS_RESET_CONTROL, 8'h00);
  endtask : soft_clear
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (90000) @(posedge core_clk);
    failures++;
    give_verdict();
  end

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    failures = 0;
    cmp_count = 0;
    pulses = 0;
    exp_rw = '0;
    exp_rate = RATE_384K;
    seed = $urandom(32'h786C);
    for (int k = 0; k < NUM_RO; k++)
      ro_image[8*k+:8] = 8'($urandom);
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    host.hold(8);
    rd_chk("reset_control", OFS_RESET_CONTROL, 8'h00);
    rd_chk("ctrl_one", OFS_DEVICE_CONTROL_ONE, 8'h00);
    // An unlisted offset is only ever read here, never written.
    rd_chk("unlisted", 8'h10, 8'h00);
    for (int k = 0; k < NUM_RW; k++)
    begin
      d = 8'($urandom);
      wr(RW_OFFSET[k], d);
      exp_rw[8*k+:8] = d;
      chk("rw_image", rw_image, exp_rw);
      rd_chk("rw_read", RW_OFFSET[k], d);
    end
    for (int k = 0; k < NUM_RO; k++)
      rd_chk("ro_read", RO_OFFSET[k], ro_image[8*k+:8]);
    // Reserved codes 5-7 follow the 768K code so that a held rate is told apart from a reset one.
    for (int f = 0; f < 8; f++)
    begin
      d = {1'b0, 3'(f), 1'b0, 1'($urandom), 2'(f % 3)};
      wr(OFS_DEVICE_CONTROL_ONE, d);
      exp_rate = rate_of(3'(f), exp_rate);
      chk("mode", mode, {d[6:4], d[2:0]});
      chk("rate", switch_rate_khz, exp_rate);
      chk("stage", stage, stage_of(d[2], d[1:0]));
      rd_chk("ctrl_one", OFS_DEVICE_CONTROL_ONE, d);
    end
    wr(OFS_RESET_CONTROL, 8'hEE);
    rd_chk("reset_control", OFS_RESET_CONTROL, 8'hE0);
    soft_clear(8'h01);
    chk("pulses", pulses, 0);
    wr(RW_OFFSET[0], 8'h5A);
    wr(OFS_DEVICE_CONTROL_ONE, 8'h47);
    soft_clear(8'h10);
    chk("pulses", pulses, 1);
    wr(OFS_DEVICE_CONTROL_ONE, 8'h31);
    wr(RW_OFFSET[NUM_RW-1], 8'hA5);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("rw_image", rw_image, '0);
    chk("mode", mode, 6'h00);
    chk("rate", switch_rate_khz, RATE_384K);
    chk("busy", busy, 1'b0);
    chk("sda_out", sda_out, 1'b0);
    give_verdict();
  end
endmodule : tb
